// ===== rtl/quad_adc_digital_datapath.sv
// How it works
// - inputs are captured and processing starts on each rising sample-clock edge with ce high
// - samples move one stage per clock with ce high; output appears 11 enabled cycles after sampling in one-lane mode
// - each result leaves as a 12-bit serial word, offset binary or twos complement
// - per-channel digital gain from 0 dB to 12 dB in 1 dB steps
// - after reset every channel gain is 0 dB
// - gain codes are written into registers 0x2A and 0x2B
// - full-scale input range shrinks with each gain step
// - per-channel swap bits in register 0x24 negate that channel
// - overload saturates to FFFh/000h offset binary, 7FFh/800h twos complement
// - two-lane arrangement makes total latency 15 cycles
module quad_adc_digital_datapath
  import quad_adc_pkg::*;
(
  // sample clock domain
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // analog inputs as digitised levels, one pair per channel
  input wire logic [WORD_W-1:0] analogInPos [NUM_CH],
  input wire logic [WORD_W-1:0] analogInNeg [NUM_CH],
  // output options
  input wire logic twosComplementSelect,
  input wire logic twoLaneSelect,
  // serial control port pins
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic serialEnable_n,
  // parallel result, sample clock domain
  output logic [WORD_W-1:0] sampleWord [NUM_CH],
  // link domain
  input wire logic linkClk,
  input wire logic linkReset,
  output logic [1:0] laneBits [NUM_CH],
  output logic frameMark
);

  // gain factor in fixed point: round(2^10 * 10^(dB/20))
  function automatic logic [GAIN_MUL_W-1:0] gain_factor(input logic [GAIN_CODE_W-1:0] db);
    case (db)
      4'h0: gain_factor = 13'h0400;
      4'h1: gain_factor = 13'h047D;
      4'h2: gain_factor = 13'h0509;
      4'h3: gain_factor = 13'h05A6;
      4'h4: gain_factor = 13'h0657;
      4'h5: gain_factor = 13'h071D;
      4'h6: gain_factor = 13'h07FB;
      4'h7: gain_factor = 13'h08F4;
      4'h8: gain_factor = 13'h0A0C;
      4'h9: gain_factor = 13'h0B46;
      4'hA: gain_factor = 13'h0CA6;
      4'hB: gain_factor = 13'h0E31;
      default: gain_factor = 13'h0FED; // codes above 12 behave as 12 dB
    endcase
  endfunction : gain_factor

  // sign, swap, gain, clamp and format one sample
  function automatic logic [WORD_W-1:0] process_sample(
    input logic [WORD_W-1:0] pos,
    input logic [WORD_W-1:0] neg,
    input logic swap,
    input logic [GAIN_CODE_W-1:0] db,
    input logic twos
  );
    logic signed [DIFF_W-1:0] diff;
    logic signed [DIFF_W+GAIN_MUL_W:0] prod;
    logic signed [DIFF_W+GAIN_MUL_W:0] scaled;
    logic signed [WORD_W-1:0] clipped;
    diff = swap ? $signed({1'b0, neg}) - $signed({1'b0, pos}) : $signed({1'b0, pos}) - $signed({1'b0, neg});
    prod = diff * $signed({1'b0, gain_factor(db)});
    scaled = prod >>> GAIN_FRAC;
    if (scaled > CODE_POS_MAX) begin
      clipped = CODE_POS_MAX;
    end else if (scaled < CODE_NEG_MAX) begin
      clipped = CODE_NEG_MAX;
    end else begin
      clipped = scaled[WORD_W-1:0];
    end
    process_sample = twos ? clipped : (clipped ^ OFFSET_FLIP);
  endfunction : process_sample

  // serial port pins cross into the sample clock domain
  logic [2:0] sclkSync;
  logic [1:0] sdataSync;
  logic [2:0] senSync;
  always_ff @(posedge clk) begin
    if (reset) begin
      sclkSync <= 3'h0;
      sdataSync <= 2'h0;
      senSync <= 3'h7;
    end else if (ce) begin
      sclkSync <= {sclkSync[1:0], serialClk};
      sdataSync <= {sdataSync[0], serialData};
      senSync <= {senSync[1:0], serialEnable_n};
    end
  end

  // 8 address bits then 16 data bits, MSB first; committed when enable rises
  logic [FRAME_BITS-1:0] shiftIn;
  logic [4:0] bitCount;
  logic commitFrame;
  assign commitFrame = ce && senSync[1] && !senSync[2] && bitCount == FRAME_BITS_CNT;
  always_ff @(posedge clk) begin
    if (reset) begin
      shiftIn <= '0;
      bitCount <= 5'h0;
    end else if (ce) begin
      if (senSync[1]) begin
        bitCount <= 5'h0;
      end else if (sclkSync[1] && !sclkSync[2] && bitCount != FRAME_BITS_CNT) begin
        shiftIn <= {shiftIn[FRAME_BITS-2:0], sdataSync[1]};
        bitCount <= bitCount + 5'h1;
      end
    end
  end

  logic [REG_W-1:0] inputPolarity;
  logic [REG_W-1:0] gainA;
  logic [REG_W-1:0] gainB;
  always_ff @(posedge clk) begin
    if (reset) begin
      inputPolarity <= RESET_POLARITY;
      gainA <= RESET_GAIN;
      gainB <= RESET_GAIN;
    end else if (commitFrame) begin
      case (shiftIn[FRAME_BITS-1:REG_W])
        ADDR_INPUT_POLARITY: inputPolarity <= shiftIn[REG_W-1:0];
        ADDR_GAIN_A: gainA <= shiftIn[REG_W-1:0];
        ADDR_GAIN_B: gainB <= shiftIn[REG_W-1:0];
        default: ;
      endcase
    end
  end

  logic [NUM_CH-1:0] swapBits;
  logic [GAIN_CODE_W-1:0] gainCode [NUM_CH];
  assign swapBits = {inputPolarity[SWAP_POS_CH4], inputPolarity[SWAP_POS_CH3],
                     inputPolarity[SWAP_POS_CH2], inputPolarity[SWAP_POS_CH1]};
  assign gainCode[0] = gainA[GAIN_LO_POS +: GAIN_CODE_W];
  assign gainCode[1] = gainA[GAIN_HI_POS +: GAIN_CODE_W];
  assign gainCode[2] = gainB[GAIN_LO_POS +: GAIN_CODE_W];
  assign gainCode[3] = gainB[GAIN_HI_POS +: GAIN_CODE_W];

  // pipeline: stage 0 loads on the sampling edge, stage k holds it k edges later
  logic [WORD_W-1:0] pipe [NUM_CH][PIPE_DEPTH];
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int s = 0; s < PIPE_DEPTH; s++) begin
          pipe[c][s] <= '0;
        end
      end
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        pipe[c][0] <= process_sample(analogInPos[c], analogInNeg[c], swapBits[c],
                                     gainCode[c], twosComplementSelect);
        for (int s = 1; s < PIPE_DEPTH; s++) begin
          pipe[c][s] <= pipe[c][s-1];
        end
      end
    end
  end

  // output register sits at the end so the word is visible after edge 11 or 15
  localparam int TAP_ONE = LAT_ONE_LANE - 1;
  localparam int TAP_TWO = LAT_TWO_LANE - 1;
  logic wordToggle;
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int c = 0; c < NUM_CH; c++) begin
        sampleWord[c] <= '0;
      end
      wordToggle <= 1'b0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        sampleWord[c] <= twoLaneSelect ? pipe[c][TAP_TWO] : pipe[c][TAP_ONE];
      end
      wordToggle <= ~wordToggle;
    end
  end

  // link domain: toggle handshake; word stays stable a full sample period after a toggle
  logic [2:0] toggleSync;
  logic [WORD_W-1:0] serShift [NUM_CH];
  logic [2:0] serCount;
  always_ff @(posedge linkClk) begin
    if (linkReset) begin
      toggleSync <= 3'h0;
    end else begin
      toggleSync <= {toggleSync[1:0], wordToggle};
    end
  end

  // two bits per link clock, MSB first; six link clocks fit in one sample period
  always_ff @(posedge linkClk) begin
    if (linkReset) begin
      serCount <= SER_LAST;
      frameMark <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        serShift[c] <= '0;
        laneBits[c] <= 2'h0;
      end
    end else if (toggleSync[1] != toggleSync[2]) begin
      serCount <= 3'h0;
      frameMark <= 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        laneBits[c] <= sampleWord[c][WORD_W-1 -: 2];
        serShift[c] <= {sampleWord[c][WORD_W-3:0], 2'h0};
      end
    end else if (serCount != SER_LAST) begin
      serCount <= serCount + 3'h1;
      frameMark <= 1'b0;
      for (int c = 0; c < NUM_CH; c++) begin
        laneBits[c] <= serShift[c][WORD_W-1 -: 2];
        serShift[c] <= {serShift[c][WORD_W-3:0], 2'h0};
      end
    end else begin
      frameMark <= 1'b0;
    end
  end

endmodule : quad_adc_digital_datapath

// ===== rtl/quad_adc_pkg.sv
package quad_adc_pkg;
  localparam int NUM_CH = 4;
  localparam int WORD_W = 12;
  localparam int DIFF_W = 13;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  localparam int FRAME_BITS = ADDR_W + REG_W;
  localparam logic [4:0] FRAME_BITS_CNT = 5'h18;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_INPUT_POLARITY = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_A = 8'h2A;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_B = 8'h2B;
  localparam logic [REG_W-1:0] RESET_POLARITY = 16'h0000;
  localparam logic [REG_W-1:0] RESET_GAIN = 16'h0000;

  // input_swap_bits positions in the polarity register, channel 1..4
  localparam int SWAP_POS_CH1 = 1;
  localparam int SWAP_POS_CH2 = 3;
  localparam int SWAP_POS_CH3 = 6;
  localparam int SWAP_POS_CH4 = 8;
  // per_channel_gain_code fields: low nibble = first channel, next nibble = second
  localparam int GAIN_CODE_W = 4;
  localparam int GAIN_LO_POS = 0;
  localparam int GAIN_HI_POS = 4;
  localparam logic [GAIN_CODE_W-1:0] GAIN_MAX_DB = 4'hC;

  // latency in sample-clock cycles
  localparam int LAT_ONE_LANE = 11;
  localparam int LAT_TWO_LANE = 15;
  localparam int PIPE_DEPTH = LAT_TWO_LANE;

  // gain multiplier, fixed point with this many fraction bits
  localparam int GAIN_FRAC = 10;
  localparam int GAIN_MUL_W = 13;

  // clamp and overload codes, signed view
  localparam logic signed [WORD_W-1:0] CODE_POS_MAX = 12'sh7FF;
  localparam logic signed [WORD_W-1:0] CODE_NEG_MAX = 12'sh800;
  localparam logic [WORD_W-1:0] OFFSET_FLIP = 12'h800;

  // serializer: two bits per link clock, six link clocks per word
  localparam logic [2:0] SER_LAST = 3'h5;
endpackage : quad_adc_pkg

// ===== verification/quad_adc_chk.sv
module quad_adc_chk
  import quad_adc_pkg::*;
(
  // sample side
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WORD_W-1:0] analogInPos [NUM_CH],
  input wire logic [WORD_W-1:0] analogInNeg [NUM_CH],
  input wire logic twosComplementSelect,
  input wire logic twoLaneSelect,
  input wire logic [WORD_W-1:0] sampleWord [NUM_CH],
  // link side
  input wire logic linkClk,
  input wire logic linkReset,
  input wire logic frameMark
);
  timeunit 1ns;
  timeprecision 100ps;
  // unbroken ce run, so latency checks never look across a freeze
  logic [4:0] run;
  always_ff @(posedge clk) run <= (reset || !ce) ? 5'h00 : run + {4'h0, run != 5'h1F};
  reset_clear_a: assert property (@(posedge clk) disable iff (reset) $fell(reset) |-> sampleWord[0] == 12'h000)
    else $error("word not cleared");
  link_clear_a: assert property (@(posedge linkClk) disable iff (linkReset) $fell(linkReset) |-> !frameMark)
    else $error("mark after link reset");
  frame_gap_a: assert property (@(posedge linkClk) disable iff (linkReset) frameMark |=> !frameMark [*5])
    else $error("mark too soon");
  freeze_hold_a: assert property (@(posedge clk) disable iff (reset) !ce |=> $stable(sampleWord[1]))
    else $error("word moved while frozen");
  pos_over_a: assert property (@(posedge clk) disable iff (reset) run >= 5'h0C && !$past(twoLaneSelect)
    && $past(analogInPos[0], 12) == 12'hFFF && $past(analogInNeg[0], 12) == 12'h000
    |-> (sampleWord[0] ^ ($past(twosComplementSelect, 12) ? 12'h000 : 12'h800)) inside {12'h7FF, 12'h800})
    else $error("overload code wrong");
  neg_over_a: assert property (@(posedge clk) disable iff (reset) run >= 5'h0C && !$past(twoLaneSelect)
    && $past(analogInPos[2], 12) == 12'h000 && $past(analogInNeg[2], 12) == 12'hFFF
    |-> (sampleWord[2] ^ ($past(twosComplementSelect, 12) ? 12'h000 : 12'h800)) inside {12'h7FF, 12'h800})
    else $error("overload code wrong");
  zero_one_a: assert property (@(posedge clk) disable iff (reset) run >= 5'h0C && !$past(twoLaneSelect)
    && $past(analogInPos[1], 12) == $past(analogInNeg[1], 12)
    |-> sampleWord[1] == ($past(twosComplementSelect, 12) ? 12'h000 : 12'h800)) else $error("one lane latency");
  zero_two_a: assert property (@(posedge clk) disable iff (reset) run >= 5'h10 && $past(twoLaneSelect)
    && $past(analogInPos[3], 16) == $past(analogInNeg[3], 16)
    |-> sampleWord[3] == ($past(twosComplementSelect, 16) ? 12'h000 : 12'h800)) else $error("two lane latency");
endmodule : quad_adc_chk
bind quad_adc_digital_datapath quad_adc_chk u_chk (.clk, .reset, .ce, .analogInPos, .analogInNeg,
  .twosComplementSelect, .twoLaneSelect, .sampleWord, .linkClk, .linkReset, .frameMark);

// ===== verification/quad_adc_link_rx.sv
module quad_adc_link_rx
  import quad_adc_pkg::*;
(
  // link side
  input wire logic linkClk,
  input wire logic [1:0] laneBits [NUM_CH],
  input wire logic frameMark,
  // received words
  output logic [WORD_W-1:0] rxWord [NUM_CH]
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [WORD_W-1:0] acc [NUM_CH];
  int pairs = 0;
  always @(posedge linkClk) begin
    for (int c = 0; c < NUM_CH; c++) acc[c] = {frameMark ? 10'h000 : acc[c][9:0], laneBits[c]};
    pairs = frameMark ? 1 : pairs + 1;
    if (pairs == 6) rxWord = acc;
  end
endmodule : quad_adc_link_rx

// ===== verification/test_quad_adc_digital_datapath.sv
module test_quad_adc_digital_datapath
  import quad_adc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, reset = 1, ce = 0, twosComplementSelect = 0, twoLaneSelect = 0, frameMark;
  logic serialClk = 0, serialData = 0, serialEnable_n = 1, linkClk = 0, linkReset = 1;
  logic [WORD_W-1:0] analogInPos [NUM_CH], analogInNeg [NUM_CH], sampleWord [NUM_CH], rxWord [NUM_CH];
  logic [1:0] laneBits [NUM_CH];
  logic [WORD_W-1:0] q [NUM_CH][$];
  int failures = 0, compares = 0, cycles = 0, lat, gain [NUM_CH];
  bit swap [NUM_CH], prevCe, newCe;
  always #50 clk = ~clk;
  initial begin
    #3.3;
    forever #6 linkClk = ~linkClk;
  end
  quad_adc_digital_datapath u_dut (.clk, .reset, .ce, .analogInPos, .analogInNeg, .twosComplementSelect,
    .twoLaneSelect, .serialClk, .serialData, .serialEnable_n, .sampleWord, .linkClk, .linkReset, .laneBits, .frameMark);
  quad_adc_link_rx u_rx (.linkClk, .laneBits, .frameMark, .rxWord);
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // each serial level held four clocks, the port samples through a slow synchroniser
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [23:0] f;
    f = {a, d};
    tick(1);
    serialEnable_n <= 1'b0;
    tick(4);
    for (int i = 47; i >= 0; i--) begin
      serialData <= f[i / 2];
      serialClk <= !i[0];
      tick(4);
    end
    serialClk <= 1'b0;
    tick(4);
    serialEnable_n <= 1'b1;
    tick(8);
  endtask : wr
  function automatic logic [11:0] expv(int p, int n, bit s, int g, logic t);
    int d;
    d = ((s ? n - p : p - n) * $rtoi(1024.0 * 10.0 ** ((g > 12 ? 12 : g) / 20.0) + 0.5)) >>> 10;
    d = d > 2047 ? 2047 : (d < -2048 ? -2048 : d);
    return 12'(d) ^ (t ? 12'h000 : 12'h800);
  endfunction : expv
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    for (int c = 0; c < NUM_CH; c++) begin
      analogInPos[c] = 12'h000;
      analogInNeg[c] = 12'h000;
    end
    void'($urandom(62308));
    tick(6);
    reset <= 1'b0;
    linkReset <= 1'b0;
    for (int ph = 0; ph < 5; ph++) begin
      for (int c = 0; c < NUM_CH; c++) begin
        gain[c] = ph == 0 ? 0 : ph * 4 + c - 4;
        swap[c] = ph != 0 && $urandom_range(1);
      end
      if (ph != 0) begin
        wr(8'h2A, {8'h00, 4'(gain[1]), 4'(gain[0])});
        wr(8'h2B, {8'h00, 4'(gain[3]), 4'(gain[2])});
        wr(8'h24, {7'h00, swap[3], 1'b0, swap[2], 2'h0, swap[1], 1'b0, swap[0], 1'b0});
        wr(8'h25, 16'hFFFF);
      end
      lat = ph[0] ? LAT_TWO_LANE : LAT_ONE_LANE;
      for (int c = 0; c < NUM_CH; c++) q[c].delete();
      for (int it = 0; it < 170; it++) begin
        @(posedge clk);
        prevCe = ce;
        newCe = it >= 150 || $urandom_range(7) != 0;
        ce <= newCe;
        twoLaneSelect <= ph[0];
        twosComplementSelect <= it >= 150 ? ph > 2 : 1'($urandom);
        for (int c = 0; c < NUM_CH; c++) begin
          analogInPos[c] <= it < 150 ? 12'($urandom) : (c == 0 ? 12'hFFF : 12'h000);
          analogInNeg[c] <= it < 150 ? 12'($urandom) : (c == 2 ? 12'hFFF : 12'h000);
        end
        @(negedge clk);
        for (int c = 0; c < NUM_CH; c++) begin
          if (prevCe && q[c].size() == lat + 1) chk("sampleWord", sampleWord[c], q[c].pop_front());
          if (newCe) q[c].push_back(expv(analogInPos[c], analogInNeg[c], swap[c], gain[c], twosComplementSelect));
        end
      end
      for (int c = 0; c < NUM_CH; c++) chk("rxWord", rxWord[c], q[c][0]);
      $display("test %0d done", ph);
    end
    end_sim();
  end
endmodule : test_quad_adc_digital_datapath
